/* File: core/csp_pkg.sv */
// Purpose: shared constants and helpers of the clocked serial port control block
// Assumes: registers reached over a plain byte/halfword cpu port at full addresses
// Notes:   ctl1, rx and tx addresses are local choices
package csp_pkg;
   localparam int              CSP_AW         = 28;
   localparam int              CSP_DW         = 16;
   localparam logic [27:0]     CSP_ADDR_CTL0  = 28'hFFF_FD00;
   localparam logic [27:0]     CSP_ADDR_CTL1  = 28'hFFF_FD01;
   localparam logic [27:0]     CSP_ADDR_CTL2  = 28'hFFF_FD02;
   localparam logic [27:0]     CSP_ADDR_STR   = 28'hFFF_FD03;
   localparam logic [27:0]     CSP_ADDR_RX    = 28'hFFF_FD04;
   localparam logic [27:0]     CSP_ADDR_TX    = 28'hFFF_FD06;
   // main_control and status bit positions
   localparam int              CSP_B_PWR      = 7;
   localparam int              CSP_B_TXE      = 6;
   localparam int              CSP_B_RXE      = 5;
   localparam int              CSP_B_DIR      = 4;
   localparam int              CSP_B_TMS      = 1;
   localparam int              CSP_B_SCE      = 0;
   localparam int              CSP_B_TSF      = 7;
   localparam int              CSP_B_OVE      = 0;
   localparam logic [7:0]      CSP_CTL0_RST   = 8'h01;
   localparam logic [7:0]      CSP_CTL1_RST   = 8'h00;
   localparam logic [3:0]      CSP_CTL2_RST   = 4'h0;
   localparam logic [15:0]     CSP_WORD_RST   = 16'h0000;
   // mode bits frozen while the unit is on; bits 3 and 2 never stored
   localparam logic [7:0]      CSP_CTL0_LOCK  = 8'h72;
   localparam logic [7:0]      CSP_CTL0_FREE  = 8'h81;
   localparam logic [2:0]      CSP_CKS_BAUD   = 3'h6;
   localparam logic [2:0]      CSP_CKS_SLAVE  = 3'h7;
   localparam logic [4:0]      CSP_LEN_BASE   = 5'h08;
   localparam logic [4:0]      CSP_LEN_MAX    = 5'h10;

   typedef enum logic {CSP_IDLE = 1'b0, CSP_SHIFT = 1'b1} csp_state_t;

   // word length in bits from the length field
   function automatic logic [4:0] csp_len(input logic [3:0] cl);
      return cl[3] ? CSP_LEN_MAX : 5'(CSP_LEN_BASE + {2'b00, cl[2:0]});
   endfunction

   // ones over the used low bits of a word
   function automatic logic [15:0] csp_mask(input logic [4:0] len);
      return 16'((17'h0_0001 << len) - 17'h0_0001);
   endfunction
endpackage

/* File: core/csp_clkdiv.sv */
// Purpose: communication clock enable for master mode
// Assumes: baud generator clock arrives as a one-cycle enable
// Notes:   tick marks each half period of the serial clock
`timescale 1ns/1ps
module csp_clkdiv #(
   parameter int CW = 6
) (
   input  wire logic       clk_sys_in,    // system clock
   input  wire logic       nrst_in,       // async reset, low
   input  wire logic       run_in,        // divider running
   input  wire logic [2:0] cks_in,        // clock select code
   input  wire logic       baud_in,       // baud generator enable
   output logic            tick_out       // half-period enable
);
   import csp_pkg::*;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] mask;
   logic          div_hit;

   // code k halves every 2^k system clocks
   assign mask     = CW'(({1'b0, {CW{1'b1}}} << cks_in) ^ {1'b0, {CW{1'b1}}});
   assign div_hit  = (cnt_reg & mask) == mask;
   assign tick_out = run_in && ((cks_in == CSP_CKS_BAUD) ? baud_in : div_hit);

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= run_in ? CW'(cnt_reg + 1'b1) : '0;
      end
   end
endmodule

/* File: core/csp_fifo2.sv */
// Purpose: two-entry buffer between the transmit buffer and the shifter
// Assumes: flush has priority over push and pop
// Notes:   in_ready low only when both entries hold words
`timescale 1ns/1ps
module csp_fifo2 #(
   parameter int W = 16
) (
   input  wire logic         clk_sys_in,  // system clock
   input  wire logic         nrst_in,     // async reset, low
   input  wire logic         flush_in,    // drop all words
   input  wire logic         in_valid_in, // word offered
   output logic              in_ready_out,// room for a word
   input  wire logic [W-1:0] in_data_in,  // word in
   output logic              out_valid_out,// word waiting
   input  wire logic         out_ready_in,// consumer takes word
   output logic [W-1:0]      out_data_out // oldest word
);
   logic [W-1:0] d0_reg;
   logic [W-1:0] d1_reg;
   logic [1:0]   cnt_reg;
   logic         push;
   logic         pop;

   assign in_ready_out  = cnt_reg != 2'h2;
   assign out_valid_out = cnt_reg != 2'h0;
   assign out_data_out  = d0_reg;
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_ready_in && out_valid_out;

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         d0_reg  <= '0;
         d1_reg  <= '0;
         cnt_reg <= 2'h0;
      end else if (flush_in) begin
         cnt_reg <= 2'h0;
      end else begin
         if (pop) begin
            d0_reg <= (push && cnt_reg == 2'h1) ? in_data_in : d1_reg;
         end else if (push && cnt_reg == 2'h0) begin
            d0_reg <= in_data_in;
         end
         if (push && (cnt_reg == 2'h2 - 2'(pop))) begin
            d1_reg <= in_data_in;
         end
         cnt_reg <= 2'(cnt_reg + 2'(push) - 2'(pop));
      end
   end
endmodule

/* File: core/csp_ctrl.sv */
// Purpose: control, status and shifting of a three-wire clocked serial port
// Assumes: cpu strobes and serial pins synchronous to clk_sys_in
// Notes:   communication type: idle high, output on fall, sample on rise
// Behaviour
// - single reception: dummy receive read with trigger set starts next reception
// - receive read with start trigger at 1 begins a new communication
// - continuous reception restarts if trigger set one clock before last word ends
// - clock select writable only while unit is off; byte wide, resets 00H
// - codes 000-101 divide by 2..64, 110 baud clock, 111 slave mode
// - length register writable when unit off or tx and rx both off
// - length codes 0000-0111 give 8-15 bits, top bit set gives 16
// - short words LSB-aligned; unused received upper bits read zero
// - clearing unit enable or reset zeroes the status register
// - transfer-active set on tx write or dummy read, cleared at last edge
// - transfer-active flag is read-only
// - overrun set when a reception completes before previous word was read
// - overrun flag works in single and continuous mode, only with rx enabled; never set in transmit-only use
// - writing 0 clears overrun, writing 1 has no effect
// - receive-complete irq on buffer update with rx enabled or on overrun
// - single mode raises receive-complete irq after every transfer
// - continuous tx modes raise tx-enable irq when buffer frees; never single
// - unit off stops clock output, resets internal state and status
// - tx modes start on transmit write; receive-only starts on receive read
`timescale 1ns/1ps
module csp_ctrl (
   input  wire logic                        clk_sys_in,             // 10 MHz clock
   input  wire logic                        nrst_in,                // async reset, low
   input  wire logic [csp_pkg::CSP_AW-1:0]  addr_in,                // register address
   input  wire logic                        wr_in,                  // write strobe
   input  wire logic                        rd_in,                  // read strobe
   input  wire logic [csp_pkg::CSP_DW-1:0]  wdata_in,               // write data
   output logic [csp_pkg::CSP_DW-1:0]       rdata_out,              // read data
   input  wire logic                        baud_gen_clock_in,      // baud enable pulse
   input  wire logic                        serial_clock_pin_in,    // clock pin level
   output logic                             serial_clock_pin_out,   // clock pin drive
   output logic                             serial_clock_pin_oe_out,// clock pin enable
   input  wire logic                        serial_in_pin_in,       // serial data in
   output logic                             serial_out_pin_out,     // serial data out
   output logic                             rx_complete_irq_out,    // receive complete
   output logic                             tx_enable_irq_out       // transmit enable
);
   import csp_pkg::*;

   logic [7:0]  ctl0_reg;
   logic [7:0]  ctl1_reg;
   logic [3:0]  ctl2_reg;
   logic [7:0]  ctl0_next;
   logic        tsf_reg;
   logic        ove_reg;
   logic        unread_reg;
   logic [15:0] rx_buf_reg;
   logic [15:0] tx_hold_reg;
   logic [15:0] sh_reg;
   logic [15:0] sh_shift;
   logic [4:0]  bit_cnt_reg;
   csp_state_t  state_reg;
   logic        sck_reg;
   logic        sck_prev_reg;
   logic        sout_reg;
   logic        sce_late_reg;
   logic        rx_irq_reg;
   logic        tx_irq_reg;
   logic        sck_oe_reg;
   logic [15:0] rdata_reg;

   // bit to drive for a word: lowest first or top bit first
   function automatic logic out_bit(input logic [15:0] d, input logic lsb_first,
                                    input logic [3:0] top);
      return lsb_first ? d[0] : d[top];
   endfunction

   wire         pwr      = ctl0_reg[CSP_B_PWR];
   wire         txe      = ctl0_reg[CSP_B_TXE];
   wire         rxe      = ctl0_reg[CSP_B_RXE];
   wire         dir      = ctl0_reg[CSP_B_DIR];
   wire         tms      = ctl0_reg[CSP_B_TMS];
   wire         sce      = ctl0_reg[CSP_B_SCE];
   wire [2:0]   cks      = ctl1_reg[2:0];
   wire         master   = cks != CSP_CKS_SLAVE;
   wire [4:0]   len      = csp_len(ctl2_reg);
   wire [3:0]   top_idx  = 4'(len - 5'h01);
   wire [15:0]  len_mask = csp_mask(len);
   wire         busy     = state_reg == CSP_SHIFT;

   wire         wr_ctl0  = wr_in && addr_in == CSP_ADDR_CTL0;
   wire         wr_ctl1  = wr_in && addr_in == CSP_ADDR_CTL1;
   wire         wr_ctl2  = wr_in && addr_in == CSP_ADDR_CTL2;
   wire         wr_str   = wr_in && addr_in == CSP_ADDR_STR;
   wire         wr_tx    = wr_in && addr_in == CSP_ADDR_TX;
   wire         rd_rx    = rd_in && addr_in == CSP_ADDR_RX;

   // writes during a single transfer are dropped
   wire         push_valid = wr_tx && pwr && txe && (tms || !tsf_reg);
   wire         push_ready;
   wire         push       = push_valid && push_ready;
   wire         f_valid;
   wire [15:0]  f_data;
   wire         tick;

   wire         rise_ev  = busy && (master ? (tick && !sck_reg)
                                           : (serial_clock_pin_in && !sck_prev_reg));
   wire         fall_ev  = busy && (master ? (tick && sck_reg)
                                           : (!serial_clock_pin_in && sck_prev_reg));
   wire         last_bit = bit_cnt_reg == 5'(len - 5'h01);
   wire         done     = rise_ev && last_bit;
   wire         pre_last = bit_cnt_reg == 5'(len - 5'h02);

   wire         load_tx  = pwr && txe && f_valid && (!busy || (done && tms));
   // receive-only start: dummy read with trigger, or automatic restart
   wire         rx_go    = pwr && rxe && !txe
                           && ((rd_rx && sce && !tsf_reg)
                               || (done && tms && sce_late_reg));
   wire         start    = load_tx || rx_go;
   wire [15:0]  start_d  = load_tx ? f_data : CSP_WORD_RST;
   wire [15:0]  rx_word  = sh_shift & len_mask;
   wire         ove_set  = done && rxe && unread_reg && !rd_rx;

   // mode bits only move while the unit is off
   assign ctl0_next = ((pwr ? ctl0_reg : wdata_in[7:0]) & CSP_CTL0_LOCK)
                      | (wdata_in[7:0] & CSP_CTL0_FREE);

   wire [15:0]  rd_mux =
      (addr_in == CSP_ADDR_CTL0) ? {8'h00, ctl0_reg} :
      (addr_in == CSP_ADDR_CTL1) ? {8'h00, ctl1_reg} :
      (addr_in == CSP_ADDR_CTL2) ? {12'h000, ctl2_reg} :
      (addr_in == CSP_ADDR_STR)  ? {8'h00, tsf_reg, 6'h00, ove_reg} :
      (addr_in == CSP_ADDR_RX)   ? rx_buf_reg :
      (addr_in == CSP_ADDR_TX)   ? tx_hold_reg : CSP_WORD_RST;

   // shift one bit in at the bottom or at the word top
   always_comb begin
      sh_shift = dir ? (sh_reg >> 1) : (sh_reg << 1);
      if (dir) begin
         sh_shift[top_idx] = serial_in_pin_in;
      end else begin
         sh_shift[0] = serial_in_pin_in;
      end
   end

   csp_clkdiv #(.CW(6)) u_div (
      .clk_sys_in (clk_sys_in),
      .nrst_in    (nrst_in),
      .run_in     (busy && master),
      .cks_in     (cks),
      .baud_in    (baud_gen_clock_in),
      .tick_out   (tick)
   );

   csp_fifo2 #(.W(16)) u_txq (
      .clk_sys_in    (clk_sys_in),
      .nrst_in       (nrst_in),
      .flush_in      (!pwr),
      .in_valid_in   (push_valid),
      .in_ready_out  (push_ready),
      .in_data_in    (wdata_in),
      .out_valid_out (f_valid),
      .out_ready_in  (load_tx),
      .out_data_out  (f_data)
   );

   // control registers
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ctl0_reg    <= CSP_CTL0_RST;
         ctl1_reg    <= CSP_CTL1_RST;
         ctl2_reg    <= CSP_CTL2_RST;
         tx_hold_reg <= CSP_WORD_RST;
      end else begin
         if (wr_ctl0) begin
            ctl0_reg <= ctl0_next;
         end
         if (wr_ctl1 && !pwr) begin
            ctl1_reg <= wdata_in[7:0];
         end
         if (wr_ctl2 && (!pwr || (!txe && !rxe))) begin
            ctl2_reg <= wdata_in[3:0];
         end
         if (push) begin
            tx_hold_reg <= wdata_in;
         end
      end
   end

   // status and receive buffer
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tsf_reg    <= 1'b0;
         ove_reg    <= 1'b0;
         unread_reg <= 1'b0;
         rx_buf_reg <= CSP_WORD_RST;
      end else if (!pwr) begin
         tsf_reg    <= 1'b0;
         ove_reg    <= 1'b0;
         unread_reg <= 1'b0;
         rx_buf_reg <= CSP_WORD_RST;
      end else begin
         if (push || rx_go) begin
            tsf_reg <= 1'b1;
         end else if (done && !f_valid) begin
            tsf_reg <= 1'b0;
         end
         if (ove_set) begin
            ove_reg <= 1'b1;
         end else if (wr_str && !wdata_in[CSP_B_OVE]) begin
            ove_reg <= 1'b0;
         end
         if (done && rxe) begin
            rx_buf_reg <= rx_word;
            unread_reg <= 1'b1;
         end else if (rd_rx) begin
            unread_reg <= 1'b0;
         end
      end
   end

   // shifter and serial clock
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_reg    <= CSP_IDLE;
         sh_reg       <= CSP_WORD_RST;
         bit_cnt_reg  <= 5'h00;
         sck_reg      <= 1'b1;
         sout_reg     <= 1'b0;
         sce_late_reg <= 1'b0;
      end else if (!pwr) begin
         state_reg    <= CSP_IDLE;
         bit_cnt_reg  <= 5'h00;
         sck_reg      <= 1'b1;
         sout_reg     <= 1'b0;
      end else begin
         if (start) begin
            state_reg   <= CSP_SHIFT;
            sh_reg      <= start_d;
            bit_cnt_reg <= 5'h00;
            sout_reg    <= txe && out_bit(start_d, dir, top_idx);
         end else if (rise_ev) begin
            sh_reg      <= sh_shift;
            bit_cnt_reg <= 5'(bit_cnt_reg + 5'h01);
            state_reg   <= last_bit ? CSP_IDLE : CSP_SHIFT;
         end else if (fall_ev && bit_cnt_reg != 5'h00) begin
            sout_reg    <= txe && out_bit(sh_reg, dir, top_idx);
         end
         if (rise_ev && pre_last) begin
            sce_late_reg <= sce;
         end
         if (!busy || !master) begin
            sck_reg <= 1'b1;
         end else if (tick) begin
            sck_reg <= !sck_reg;
         end
      end
   end

   // outputs and bus read
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sck_prev_reg <= 1'b1;
         rx_irq_reg   <= 1'b0;
         tx_irq_reg   <= 1'b0;
         sck_oe_reg   <= 1'b0;
         rdata_reg    <= CSP_WORD_RST;
      end else begin
         sck_prev_reg <= serial_clock_pin_in;
         rx_irq_reg   <= pwr && done && (rxe || !tms);
         tx_irq_reg   <= load_tx && tms;
         sck_oe_reg   <= pwr && master;
         if (rd_in) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   assign serial_clock_pin_out    = sck_reg;
   assign serial_clock_pin_oe_out = sck_oe_reg;
   assign serial_out_pin_out      = sout_reg;
   assign rx_complete_irq_out     = rx_irq_reg;
   assign tx_enable_irq_out       = tx_irq_reg;
   assign rdata_out               = rdata_reg;

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!nrst_in);

   property p_rx_read_start;
      pwr && rxe && !txe && sce && !tsf_reg && rd_rx |=> tsf_reg && busy;
   endproperty
   a_rx_read_start: assert property (p_rx_read_start)
      else $error("dummy receive read did not start reception");

   property p_tx_write_flag;
      push |=> tsf_reg ##1 (busy || !pwr);
   endproperty
   a_tx_write_flag: assert property (p_tx_write_flag)
      else $error("transmit write did not raise transfer-active");

   property p_ctl1_lock;
      pwr && wr_ctl1 |=> $stable(ctl1_reg);
   endproperty
   a_ctl1_lock: assert property (p_ctl1_lock)
      else $error("clock select changed while unit enabled");

   property p_ctl2_lock;
      pwr && (txe || rxe) && wr_ctl2 |=> $stable(ctl2_reg);
   endproperty
   a_ctl2_lock: assert property (p_ctl2_lock)
      else $error("length changed while transfer enabled");

   property p_overrun;
      pwr && done && rxe && unread_reg && !rd_rx |=> ove_reg && rx_complete_irq_out;
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun not flagged");

   property p_ove_write_one;
      pwr && !ove_reg && !ove_set && wr_str |=> !ove_reg;
   endproperty
   a_ove_write_one: assert property (p_ove_write_one)
      else $error("overrun set by software write");

   property p_unit_off;
      !pwr |=> !tsf_reg && !ove_reg && !serial_clock_pin_oe_out && rx_buf_reg == CSP_WORD_RST;
   endproperty
   a_unit_off: assert property (p_unit_off)
      else $error("status not cleared with unit off");

   property p_single_irq;
      pwr && done && !tms |=> rx_complete_irq_out;
   endproperty
   a_single_irq: assert property (p_single_irq)
      else $error("no receive-complete irq after single transfer");

   property p_no_txirq_single;
      !tms && $past(!tms) |-> !tx_enable_irq_out;
   endproperty
   a_no_txirq_single: assert property (p_no_txirq_single)
      else $error("tx-enable irq in single mode");

   property p_upper_zero;
      pwr && done && rxe |=> (rx_buf_reg & ~len_mask) == CSP_WORD_RST;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("unused receive bits not zero");

   property p_auto_restart;
      pwr && done && tms && rxe && !txe && sce_late_reg |=> busy [*2];
   endproperty
   a_auto_restart: assert property (p_auto_restart)
      else $error("continuous reception did not restart");

   c_single_tx: cover property (pwr && txe && !tms && done);
   c_cont_rx: cover property (rx_go && done);
   c_overrun: cover property (ove_set);
   c_slave: cover property (pwr && !master && done);
endmodule

/* File: verif/csp_peer_model.sv */
// Purpose: serial slave peer on the port's pins
// Assumes: clock idle high, data changes on fall, sampled on rise
// Notes:   reply pattern reloads after two idle cycles
`timescale 1ns/1ps
module csp_peer_model #(
   parameter logic [15:0] PAT = 16'hC5A3  // reply word
) (
   input  wire logic   clk_sys_in, // system clock
   input  wire logic   sck_in,     // serial clock wire
   input  wire logic   mosi_in,    // data from port
   output logic        miso_out,   // data to port
   output logic [15:0] got_out     // bits taken in
);
   logic [15:0] pat_reg  = PAT;
   logic        last_reg = 1'b0;
   logic        sck_reg  = 1'b1;
   logic [1:0]  idle_reg = 2'h2;
   wire  [15:0] src      = (idle_reg == 2'h2) ? PAT : pat_reg;
   initial got_out = 16'h0000;
   // released line shows the inverse of its last bit
   assign miso_out = (idle_reg == 2'h2 && sck_in) ? ~last_reg : last_reg;
   always @(negedge sck_in) begin
      last_reg <= src[15];
      pat_reg  <= {src[14:0], src[15]};
   end
   always @(posedge sck_in) got_out <= {got_out[14:0], mosi_in};
   always @(posedge clk_sys_in) begin
      sck_reg  <= sck_in;
      idle_reg <= (sck_in != sck_reg) ? 2'h0 : idle_reg + {1'b0, idle_reg != 2'h2};
   end
endmodule

/* File: verif/clocked_serial_port_ctrl_tb_top.sv */
// Purpose: register-level bench of the serial port control block
// Assumes: peer model stands on the serial pins
// Notes:   master mode at divider codes 001 and 000 and the baud clock, then slave mode
`timescale 1ns/1ps
module clocked_serial_port_ctrl_tb_top;
   import csp_pkg::*;
   localparam logic [15:0] PAT = 16'hC5A3;
   logic              clk_sys_in = 1'b0;
   logic              nrst_in    = 1'b0;
   logic [CSP_AW-1:0] addr       = '0;
   logic              wr         = 1'b0;
   logic              rd         = 1'b0;
   logic [15:0]       wdata      = '0;
   logic [15:0]       rdata, got, m;
   logic              sck, sck_oe, miso, mosi, rx_irq, tx_irq;
   logic              ext_sck    = 1'b1;
   logic              baud       = 1'b0;
   logic [3:0]        codes [3]  = '{4'h0, 4'h7, 4'hF};
   logic [2:0]        clks [3]   = '{3'h1, 3'h6, 3'h0};
   int                bad_count  = 0;
   int                cmp_count  = 0;
   int                rx_n       = 0;
   int                tx_n       = 0;
   int                e          = 0;
   int                len;
   wire               sck_pin    = sck_oe ? sck : ext_sck;
   always #50 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) baud <= ~baud;
   always @(posedge clk_sys_in) begin
      if (rx_irq === 1'b1) rx_n++;
      if (tx_irq === 1'b1) tx_n++;
   end
   csp_ctrl uut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .addr_in(addr), .wr_in(wr),
      .rd_in(rd), .wdata_in(wdata), .rdata_out(rdata), .baud_gen_clock_in(baud),
      .serial_clock_pin_in(sck_pin), .serial_clock_pin_out(sck),
      .serial_clock_pin_oe_out(sck_oe), .serial_in_pin_in(miso), .serial_out_pin_out(mosi),
      .rx_complete_irq_out(rx_irq), .tx_enable_irq_out(tx_irq));
   csp_peer_model #(.PAT(PAT)) peer (.clk_sys_in(clk_sys_in), .sck_in(sck_pin),
      .mosi_in(mosi), .miso_out(miso), .got_out(got));
   task automatic complete_run();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [27:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_sys_in);
      wr    <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [27:0] a, input logic [15:0] exp);
      @(posedge clk_sys_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_sys_in);
      rd   <= 1'b0;
      @(posedge clk_sys_in);
      #1 chk(nm, rdata, exp);
   endtask
   task automatic wait_for(ref int c, input int n);
      for (int i = 0; i < 2000 && c < n; i++) @(posedge clk_sys_in);
      if (c < n) begin
         bad_count++;
         complete_run();
      end
   endtask
   initial begin
      repeat (4) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      rchk("ctl0", CSP_ADDR_CTL0, 16'h0001);
      rchk("ctl1", CSP_ADDR_CTL1, 16'h0000);
      rchk("ctl2", CSP_ADDR_CTL2, 16'h0000);
      rchk("str", CSP_ADDR_STR, 16'h0000);
      rchk("hole", 28'hFFF_FD0E, 16'h0000);
      wr_reg(CSP_ADDR_CTL1, 16'h0005);
      rchk("ctl1 off", CSP_ADDR_CTL1, 16'h0005);
      wr_reg(CSP_ADDR_CTL1, 16'h0000);  // 5 MHz serial clock
      foreach (codes[i]) begin
         len = codes[i][3] ? 16 : 8 + codes[i];
         m = 16'((17'h0_0001 << len) - 17'h0_0001);
         wr_reg(CSP_ADDR_CTL0, 16'h0001);
         wr_reg(CSP_ADDR_CTL1, {13'h0000, clks[i]});
         wr_reg(CSP_ADDR_CTL2, {12'h00F, codes[i]});
         rchk("ctl2", CSP_ADDR_CTL2, {12'h000, codes[i]});
         wr_reg(CSP_ADDR_CTL0, 16'h00E1);  // bits 3 and 2 left zero
         wr_reg(CSP_ADDR_TX, 16'h9A5C);
         rchk("busy", CSP_ADDR_STR, 16'h0080);
         e++;
         wait_for(rx_n, e);
         rchk("idle", CSP_ADDR_STR, 16'h0000);
         rchk("rx", CSP_ADDR_RX, PAT >> (16 - len));
         chk("peer", got & m, 16'h9A5C & m);
      end
      wr_reg(CSP_ADDR_CTL1, 16'h0003);
      rchk("ctl1 on", CSP_ADDR_CTL1, 16'h0000);
      wr_reg(CSP_ADDR_CTL2, 16'h0003);
      rchk("ctl2 on", CSP_ADDR_CTL2, 16'h000F);
      repeat (2) begin
         wr_reg(CSP_ADDR_TX, 16'h0011);
         e++;
         wait_for(rx_n, e);
      end
      rchk("ove", CSP_ADDR_STR, 16'h0001);
      wr_reg(CSP_ADDR_STR, 16'h0081);
      rchk("ove w1", CSP_ADDR_STR, 16'h0001);
      wr_reg(CSP_ADDR_STR, 16'h0000);
      rchk("ove w0", CSP_ADDR_STR, 16'h0000);
      chk("tx irq", 16'(tx_n), 16'h0000);
      wr_reg(CSP_ADDR_CTL0, 16'h0001);
      wr_reg(CSP_ADDR_CTL0, 16'h00A1);
      rchk("dummy", CSP_ADDR_RX, 16'h0000);
      rchk("rx busy", CSP_ADDR_STR, 16'h0080);
      e++;
      wait_for(rx_n, e);
      rchk("rx 1", CSP_ADDR_RX, PAT);
      rchk("again", CSP_ADDR_STR, 16'h0080);
      e++;
      wait_for(rx_n, e);
      wr_reg(CSP_ADDR_CTL0, 16'h00A0);  // trigger off before last read
      rchk("rx 2", CSP_ADDR_RX, PAT);
      rchk("stop", CSP_ADDR_STR, 16'h0000);
      wr_reg(CSP_ADDR_CTL0, 16'h0000);  // idle seen before disable
      wr_reg(CSP_ADDR_CTL0, 16'h00A3);
      rchk("c dummy", CSP_ADDR_RX, 16'h0000);
      e = e + 2;
      wait_for(rx_n, e - 1);
      wr_reg(CSP_ADDR_CTL0, 16'h00A2);  // trigger off in last word
      rchk("c rx 1", CSP_ADDR_RX, PAT);
      wait_for(rx_n, e);
      rchk("c rx 2", CSP_ADDR_RX, PAT);
      rchk("c stop", CSP_ADDR_STR, 16'h0000);
      wr_reg(CSP_ADDR_CTL0, 16'h0000);
      wr_reg(CSP_ADDR_CTL0, 16'h00C3);
      wr_reg(CSP_ADDR_TX, 16'h1234);
      wr_reg(CSP_ADDR_TX, 16'h5678);
      wait_for(tx_n, 2);
      wr_reg(CSP_ADDR_TX, 16'h0F0F);
      wr_reg(CSP_ADDR_CTL0, 16'h0000);
      rchk("abort", CSP_ADDR_STR, 16'h0000);
      chk("sck oe", {15'h0000, sck_oe}, 16'h0000);
      wr_reg(CSP_ADDR_CTL1, 16'h0007);  // external clock
      wr_reg(CSP_ADDR_CTL0, 16'h00F1);  // lsb first
      wr_reg(CSP_ADDR_TX, 16'h3C96);
      repeat (32) begin
         repeat (2) @(posedge clk_sys_in);
         ext_sck <= ~ext_sck;
      end
      e++;
      wait_for(rx_n, e);
      rchk("slv rx", CSP_ADDR_RX, PAT);
      chk("slv tx", got, 16'h693C);
      chk("slv oe", {15'h0000, sck_oe}, 16'h0000);
      complete_run();
   end
endmodule
